//--- inc/arb_consts.vh
`ifndef ARB_CONSTS_VH
`define ARB_CONSTS_VH
// Register byte offsets
`define ARB_OFS_CTRL 8'h0a
`define ARB_OFS_COUNT 8'h0b
// Control register fields
`define ARB_B_MODE_LO 0
`define ARB_B_MODE_HI 1
`define ARB_B_LOST 2
`define ARB_B_CLKSEL 3
`define ARB_B_DONE 4
`define ARB_B_RUN 5
`define ARB_B_OVFL 6
`define ARB_B_MSB 7
// Mode codes
`define ARB_MODE_IDLE 2'h0
`define ARB_MODE_MEAS 2'h1
`define ARB_MODE_ARB 2'h2
// Arbitration sample counts and counter constants
`define ARB_SAMPLE_BUS 9'h038
`define ARB_SAMPLE_PSC 9'h008
`define ARB_CNT_ZERO 9'h000
`define ARB_CNT_ONE 9'h001
`define ARB_CNT_MAX 9'h1ff
`endif

//--- hw/arb_sync.v
`timescale 1ns/100ps
// ****************************************
// Two-stage synchroniser, one per bit
// ****************************************
module arb_sync #(
  parameter WIDTH = 2
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bitsync
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
  assign sync_o = sync_q;
endmodule

//--- hw/serial_line_arbiter_counter.v
`timescale 1ns/100ps
// Function
// RQ1: 9-bit counter, overflow bit, mode control
// RQ2: Modes: idle, measurement, arbitration
// RQ3: Software never writes reserved mode 11
// RQ4: Reset clears all control and status
// RQ5: Lost flag read-only; cleared writing mode_hi 0
// RQ6: Clock select picks half prescaler or bus
// RQ7: Done flag set; cleared by control write
// RQ8: Running flag shows counter counting
// RQ9: Overflow flag set; cleared by control write
// RQ10: Mode 00 holds counter reset
// RQ11: Control exposes counter MSB; write clears
// RQ12: Data register low bits; control write clears
// RQ13: Bus clock: falling edge starts count
// RQ14: Bus clock: next falling edge stops, done
// RQ15: Prescaler clock: low level starts count
// RQ16: Prescaler clock: rising edge stops count
// RQ17: Arbitration: sample receive at fixed count
// RQ18: Lost flag forces transmit pin high
// RQ19: Transmit low before loss restarts arbitration
// RQ20: Count by one; wrap sets overflow
// RQ21: Stopped count held until write or mode change
`include "arb_consts.vh"
module serial_line_arbiter_counter (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire rx_pin_i,
  input wire internal_transmit_out_i,
  input wire psc_tick_i,
  output reg tx_pin_o,
  output reg counter_running_o
);
  // ****************************************
  // State
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_STOP = 2'h2;

  reg [1:0] arb_mode_sel_q;
  reg arb_clk_sel_q;
  reg arb_lost_flag_q;
  reg measure_done_flag_q;
  reg counter_overflow_flag_q;
  reg [8:0] count_q; // see RQ1
  reg [1:0] state_q;
  reg half_q;
  reg rx_prev_q;
  reg tx_prev_q;
  reg rx_low_seen_q;

  wire [1:0] sync_w;
  wire rx_s;
  wire psc_s;
  wire ctrl_wr;
  wire tick;
  wire rx_fall;
  wire rx_rise;
  wire tx_rise;
  wire tx_fall;
  wire [8:0] sample_pt;
  wire [8:0] count_inc;
  wire mode_idle;
  wire mode_meas;
  wire mode_arb;

  // ****************************************
  // Input synchronisers
  // ****************************************
  arb_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i({psc_tick_i, rx_pin_i}),
    .sync_o(sync_w)
  );
  assign rx_s = sync_w[0];
  assign psc_s = sync_w[1];

  assign ctrl_wr = wr_i && (addr_i == `ARB_OFS_CTRL);
  assign mode_idle = (arb_mode_sel_q == `ARB_MODE_IDLE);
  assign mode_meas = (arb_mode_sel_q == `ARB_MODE_MEAS);
  assign mode_arb = (arb_mode_sel_q == `ARB_MODE_ARB);
  assign rx_fall = rx_prev_q && !rx_s;
  assign rx_rise = !rx_prev_q && rx_s;
  assign tx_rise = !tx_prev_q && internal_transmit_out_i;
  assign tx_fall = tx_prev_q && !internal_transmit_out_i;
  assign sample_pt = arb_clk_sel_q ? `ARB_SAMPLE_PSC : `ARB_SAMPLE_BUS;
  assign count_inc = count_q + `ARB_CNT_ONE;

  // ****************************************
  // Half-rate counter tick
  // ****************************************
  // Source is bus clock or prescaler tick, halved
  wire src_tick = arb_clk_sel_q ? psc_s : 1'b1; // see RQ6
  assign tick = src_tick && half_q;

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_q <= 1'b0;
      rx_prev_q <= 1'b1;
      tx_prev_q <= 1'b1;
    end else begin
      if (state_q != ST_RUN) begin
        half_q <= 1'b0;
      end else if (src_tick) begin
        half_q <= !half_q; // see RQ6
      end
      rx_prev_q <= rx_s;
      tx_prev_q <= internal_transmit_out_i;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arb_mode_sel_q <= `ARB_MODE_IDLE; // see RQ4
      arb_clk_sel_q <= 1'b0;
    end else if (ctrl_wr) begin
      arb_mode_sel_q <= {wdata_i[`ARB_B_MODE_HI], wdata_i[`ARB_B_MODE_LO]}; // see RQ2
      arb_clk_sel_q <= wdata_i[`ARB_B_CLKSEL];
    end
  end

  // ****************************************
  // Counter and mode logic
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      count_q <= `ARB_CNT_ZERO;
      measure_done_flag_q <= 1'b0;
      counter_overflow_flag_q <= 1'b0;
      arb_lost_flag_q <= 1'b0;
      rx_low_seen_q <= 1'b0;
    end else if (ctrl_wr) begin
      // Any control write clears count, done and overflow flags; lost flag only if mode_hi is 0; mode restarts
      state_q <= ST_IDLE;
      count_q <= `ARB_CNT_ZERO; // see RQ11 see RQ12 see RQ21
      measure_done_flag_q <= 1'b0; // see RQ7
      counter_overflow_flag_q <= 1'b0; // see RQ9
      rx_low_seen_q <= 1'b0;
      if (!wdata_i[`ARB_B_MODE_HI]) begin
        arb_lost_flag_q <= 1'b0; // see RQ5
      end
    end else if (mode_idle) begin
      state_q <= ST_IDLE;
      count_q <= `ARB_CNT_ZERO; // see RQ10
    end else begin
      if (state_q == ST_RUN && tick) begin
        count_q <= count_inc; // see RQ20
        if (count_q == `ARB_CNT_MAX) begin
          counter_overflow_flag_q <= 1'b1; // see RQ20
        end
      end
      if (mode_meas) begin
        case (state_q)
          ST_IDLE: begin
            if (!arb_clk_sel_q && rx_fall) begin
              state_q <= ST_RUN; // see RQ13
            end else if (arb_clk_sel_q && !rx_s) begin
              state_q <= ST_RUN; // see RQ15
            end
          end
          ST_RUN: begin
            if ((!arb_clk_sel_q && rx_fall) || (arb_clk_sel_q && rx_rise)) begin
              state_q <= ST_STOP; // see RQ14 see RQ16
              measure_done_flag_q <= 1'b1;
            end
          end
          ST_STOP: begin
            state_q <= ST_STOP; // see RQ21
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end else if (mode_arb) begin
        // Own echo lags the transmit edge, so the line is only judged at the sample point
        if (tx_rise) begin
          state_q <= ST_RUN; // see RQ17
          count_q <= `ARB_CNT_ZERO;
          rx_low_seen_q <= 1'b0;
        end else if (tx_fall && !rx_low_seen_q && !arb_lost_flag_q) begin
          state_q <= ST_IDLE; // see RQ19
          count_q <= `ARB_CNT_ZERO;
        end else if (state_q == ST_RUN && tick && count_q == sample_pt) begin
          if (!rx_s) begin
            arb_lost_flag_q <= 1'b1; // see RQ17
            rx_low_seen_q <= 1'b1;
          end
        end
      end else begin
        // Reserved mode: counter held stopped
        state_q <= ST_IDLE;
      end
    end
  end

  // ****************************************
  // Pin outputs and read port
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_pin_o <= 1'b1;
      counter_running_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      tx_pin_o <= internal_transmit_out_i | arb_lost_flag_q; // see RQ18
      counter_running_o <= (state_q == ST_RUN);
      if (rd_i && addr_i == `ARB_OFS_CTRL) begin
        rdata_o <= {count_q[8], counter_overflow_flag_q, (state_q == ST_RUN), measure_done_flag_q,
                    arb_clk_sel_q, arb_lost_flag_q, arb_mode_sel_q}; // see RQ8 see RQ11
      end else if (rd_i && addr_i == `ARB_OFS_COUNT) begin
        rdata_o <= count_q[7:0]; // see RQ12
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end
endmodule

//--- tb/arb_chk.sv
`timescale 1ns/100ps
module arb_chk (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire internal_transmit_out_i,
  input wire tx_pin_o,
  input wire counter_running_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_wr_ctrl;
    wr_i && addr_i == 8'h0a;
  endsequence
  sequence s_rd_ctrl;
    rd_i && addr_i == 8'h0a;
  endsequence
  sequence s_wr_idle;
    s_wr_ctrl ##0 wdata_i[1:0] == 2'h0;
  endsequence
  AST_RST_VAL: assert property ($rose(nrst_i) |-> tx_pin_o && !counter_running_o && rdata_o == 8'h00)
    else $error("bad reset outputs");
  AST_RD_ZERO: assert property (!(rd_i && addr_i[7:1] == 7'h05) |=> rdata_o == 8'h00)
    else $error("read data not zero");
  AST_IDLE_CNT: assert property (s_wr_idle ##1 (rd_i && addr_i == 8'h0b) |=> rdata_o == 8'h00)
    else $error("idle count not zero");
  AST_IDLE_RUN: assert property (s_wr_idle |-> ##2 !counter_running_o)
    else $error("running in idle");
  AST_CTRL_BACK: assert property (s_wr_ctrl ##1 s_rd_ctrl |=> (rdata_o & 8'hdb) == ($past(wdata_i, 2) & 8'h0b))
    else $error("control readback wrong");
  AST_LOST_CLR: assert property (s_wr_ctrl ##0 !wdata_i[1] ##1 s_rd_ctrl |=> !rdata_o[2])
    else $error("lost flag not cleared");
  AST_LOST_TX: assert property (s_rd_ctrl ##1 rdata_o[2] |-> tx_pin_o)
    else $error("lost but pin low");
  AST_TX_PASS: assert property (internal_transmit_out_i |=> tx_pin_o)
    else $error("pin not following");
endmodule

//--- tb/bus_node.sv
`timescale 1ns/100ps
module bus_node (
  input wire tx_pin_i,
  input wire dominant_i,
  output wire rx_o
);
  // Wired-AND line with pull-up
  assign rx_o = tx_pin_i & ~dominant_i;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
bind serial_line_arbiter_counter arb_chk chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .internal_transmit_out_i(internal_transmit_out_i), .tx_pin_o(tx_pin_o),
  .counter_running_o(counter_running_o));
module tb_top;
  logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, itx = 1'h1, psc = 1'h0, dom = 1'h0, rd_seen = 1'h0;
  logic tx_pin, running, rx;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] ent, q[$];
  int errors = 0, samples_checked = 0, k;
  serial_line_arbiter_counter dut (.core_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_pin_i(rx), .internal_transmit_out_i(itx),
    .psc_tick_i(psc), .tx_pin_o(tx_pin), .counter_running_o(running));
  bus_node node (.tx_pin_i(tx_pin), .dominant_i(dom), .rx_o(rx));
  initial forever #5 clk = ~clk;
  always @(posedge clk) psc <= ~psc;
  task check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    rd <= 1'h0;
    @(posedge clk);
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] t = 8'h00);
    q.push_back({t, e});
    addr <= a;
    rd <= 1'h1;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task idle(input int n);
    wr <= 1'h0;
    rd <= 1'h0;
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rd_seen) begin
      ent = q.pop_front();
      check((rdata - ent[7:0]) <= ent[15:8] ? ent[7:0] : rdata, ent[7:0]);
    end
    rd_seen <= rd;
  end
  task results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(45920));
    k = 20 + $urandom % 40;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rreg(8'h0a, 8'h00);
    rreg(8'h0c, 8'h00);
    wreg(8'h0b, 8'($urandom));
    rreg(8'h0b, 8'h00);
    wreg(8'h0a, 8'h01);
    idle(4);
    dom <= 1'h1;
    idle(k);
    dom <= 1'h0;
    idle(k);
    dom <= 1'h1;
    idle(6);
    rreg(8'h0a, 8'h11);
    rreg(8'h0b, 8'(k - 1), 8'h02);
    wreg(8'h0a, 8'h09);
    idle(4 * k);
    rreg(8'h0a, 8'h29);
    dom <= 1'h0;
    idle(6);
    check({7'h00, running}, 8'h00);
    rreg(8'h0b, 8'(k - 1), 8'h03);
    wreg(8'h0a, 8'h01);
    idle(4);
    dom <= 1'h1;
    idle(600);
    rreg(8'h0a, 8'ha1);
    idle(500);
    rreg(8'h0a, 8'h61);
    wreg(8'h0a, 8'h00);
    rreg(8'h0b, 8'h00);
    rreg(8'h0a, 8'h00);
    dom <= 1'h0;
    itx <= 1'h0;
    idle(4);
    wreg(8'h0a, 8'h02);
    idle(2);
    itx <= 1'h1;
    idle(10);
    dom <= 1'h1;
    idle(150);
    itx <= 1'h0;
    idle(3);
    check({7'h00, tx_pin}, 8'h01);
    wreg(8'h0a, 8'h02);
    rreg(8'h0a, 8'h06);
    wreg(8'h0a, 8'h00);
    rreg(8'h0a, 8'h00);
    dom <= 1'h0;
    idle(3);
    check({7'h00, tx_pin}, 8'h00);
    wreg(8'h0a, 8'h02);
    idle(2);
    itx <= 1'h1;
    idle(10);
    rreg(8'h0a, 8'h22);
    itx <= 1'h0;
    idle(4);
    rreg(8'h0a, 8'h02);
    rreg(8'h0b, 8'h00);
    idle(3);
    results;
  end
endmodule
